// ==== src/pmc_pkg.sv ====
// Package: constants and types shared by the power mode controller ends
package pmc_pkg;
   // Clock and timing
   localparam int CLK_MHZ = 100;
   localparam int LPO_KHZ = 16;
   localparam int LPO_DIV = (CLK_MHZ * 1000) / (LPO_KHZ * 2);
   localparam int STARTUP_NS = 15000;
   localparam int STARTUP_CYC = (STARTUP_NS * CLK_MHZ + 999) / 1000;
   localparam int PDN_HOLD_NS = 10000;
   localparam int PDN_HOLD_CYC = (PDN_HOLD_NS * CLK_MHZ + 999) / 1000;
   localparam int POR_CYC = 16;
   localparam int REF_KHZ = 13560;
   // Register addresses on the link
   localparam logic [6:0] A_CMD = 7'h00;
   localparam logic [6:0] A_CTRL = 7'h01;
   localparam logic [6:0] A_FIFO = 7'h05;
   localparam logic [6:0] A_FLEN = 7'h04;
   localparam logic [6:0] A_IRQ = 7'h06;
   localparam logic [6:0] A_WUC = 7'h20;
   localparam logic [6:0] A_WTC = 7'h21;
   localparam logic [6:0] A_QMIN = 7'h3F;
   localparam logic [6:0] A_QMAX = 7'h40;
   localparam logic [6:0] A_IMIN = 7'h41;
   localparam logic [6:0] A_IRES = 7'h42;
   localparam logic [6:0] A_QRES = 7'h43;
   localparam logic [6:0] A_IMAX = 7'h44;
   // Field positions
   localparam int B_STANDBY = 7;
   localparam int B_MODEM = 6;
   localparam int B_AUTO_WAKE = 0;
   localparam int B_AUTO_RESTART = 1;
   localparam int B_TIMER_RUN = 2;
   localparam int B_CD_IRQ = 0;
   localparam int B_IDLE_IRQ = 1;
   localparam logic [7:0] WAKE_BYTE = 8'h55;
   // Command codes
   localparam logic [4:0] C_IDLE = 5'h00;
   localparam logic [4:0] C_DETECT = 5'h01;
   localparam logic [4:0] C_LOADKEY = 5'h02;
   localparam logic [4:0] C_AUTH = 5'h03;
   localparam logic [4:0] C_TRANSMIT = 5'h06;
   localparam logic [4:0] C_WRITE_E2 = 5'h08;
   // Argument bytes each command needs
   function automatic logic [3:0] pmc_args(input logic [4:0] c);
      case (c)
         C_LOADKEY: pmc_args = 4'h6;
         C_AUTH: pmc_args = 4'h6;
         C_WRITE_E2: pmc_args = 4'h3;
         default: pmc_args = 4'h0;
      endcase
   endfunction : pmc_args
   typedef enum logic [2:0] {
      PMC_OFF, PMC_POR, PMC_START, PMC_FULL, PMC_STBY
   } pmc_pwr_t;
   typedef enum logic [1:0] {
      PMC_CIDLE, PMC_CWAIT, PMC_CRUN, PMC_CDET
   } pmc_cmd_t;
endpackage : pmc_pkg

// ==== src/pmc_link_if.sv ====
// Interface: register link and power-down pin between host and device
`timescale 1ns/1ps
interface pmc_link_if;
   logic power_down_pin;
   logic wr;
   logic rd;
   logic uart_wake;
   logic [6:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic rvalid;
   modport dev (input power_down_pin, wr, rd, uart_wake, addr, wdata,
      output rdata, rvalid);
   modport host (output power_down_pin, wr, rd, uart_wake, addr, wdata,
      input rdata, rvalid);
endinterface : pmc_link_if

// ==== src/pmc_wake_counter.sv ====
// Low power oscillator tick and wake-up counter
`timescale 1ns/1ps
module pmc_wake_counter (
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   input wire logic start_i,
   input wire logic stop_i,
   input wire logic restart_i,
   input wire logic [7:0] reload_i,
   output logic expire_o,
   output logic running_o
);
   typedef struct packed {
      logic [15:0] div;
      logic [7:0] cnt;
      logic run;
      logic exp;
   } pmc_wuc_t;
   pmc_wuc_t s_r, s_nxt;

   // Divider gives 16 kHz ticks; counter counts them down
   always_comb begin
      s_nxt = s_r;
      s_nxt.exp = 1'b0;
      s_nxt.div = (s_r.div == 16'(pmc_pkg::LPO_DIV * 2 - 1)) ? 16'h0000 : s_r.div + 16'h0001;
      if (stop_i) begin
         s_nxt.run = 1'b0;
      end else if (start_i) begin
         s_nxt.run = 1'b1;
         s_nxt.cnt = reload_i;
         s_nxt.div = 16'h0000;
      end else if (s_r.run && s_r.div == 16'h0000) begin
         if (s_r.cnt == 8'h00) begin
            s_nxt.exp = 1'b1;
            s_nxt.run = restart_i;
            s_nxt.cnt = reload_i;
         end else begin
            s_nxt.cnt = s_r.cnt - 8'h01;
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign expire_o = s_r.exp;
   assign running_o = s_r.run;
endmodule : pmc_wake_counter

// ==== src/pmc_device.sv ====
// Device end: power modes, start-up sequence and command state machine
//
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/1ps
module pmc_device (
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   pmc_link_if.dev link,
   input wire logic [7:0] i_sample_i,
   input wire logic [7:0] q_sample_i,
   input wire logic [7:0] frame_cfg_i,
   output logic full_mode_o,
   output logic standby_o,
   output logic tx_on_o,
   output logic rx_on_o,
   output logic pins_oe_o,
   output logic [1:0] tx_phase_o,
   output logic [4:0] active_cmd_o,
   output logic [7:0] trim_count_o
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [2:0] pd_sync;
      logic [2:0] wk_sync;
      pmc_pkg::pmc_pwr_t pwr;
      logic [15:0] tmr;
      logic [7:0] cmd_reg;
      logic [7:0] ctrl;
      logic [7:0] wuc_reload;
      logic [7:0] wtc;
      logic [7:0] qmin, qmax, imin, imax, ires, qres;
      logic [7:0] irq;
      logic [3:0] flen;
      pmc_pkg::pmc_cmd_t cst;
      logic [4:0] cmd;
      logic [1:0] txp;
      logic [7:0] rdata;
      logic rvalid;
      logic wstart;
      logic wstop;
      logic [15:0] trim_div;
      logic [7:0] trim_cnt;
      logic [7:0] trim_res;
      logic full, stby, tx, rx, oe;
   } pmc_dev_t;
   pmc_dev_t s_r, s_nxt;
   logic wuc_exp, wuc_run;

   pmc_wake_counter u_wuc (
      .sys_clk_i(sys_clk_i),
      .rstn_i(rstn_i),
      .start_i(s_r.wstart),
      .stop_i(s_r.wstop),
      .restart_i(s_r.wtc[pmc_pkg::B_AUTO_RESTART]),
      .reload_i(s_r.wuc_reload),
      .expire_o(wuc_exp),
      .running_o(wuc_run)
   );

   // ------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------
   always_comb begin
      logic pd, wk, ready, hit;
      pd = s_r.pd_sync[1];
      wk = s_r.wk_sync[1] & ~s_r.wk_sync[2];
      s_nxt = s_r;
      s_nxt.pd_sync = {s_r.pd_sync[1:0], link.power_down_pin};
      s_nxt.wk_sync = {s_r.wk_sync[1:0], link.uart_wake};
      s_nxt.rvalid = 1'b0;
      s_nxt.wstart = 1'b0;
      s_nxt.wstop = 1'b0;
      ready = (s_r.pwr == pmc_pkg::PMC_FULL);
      hit = 1'b0;
      // Power sequencer
      if (pd) begin
         s_nxt.pwr = pmc_pkg::PMC_OFF;
         s_nxt.tmr = 16'h0000;
      end else begin
         unique case (s_r.pwr)
            pmc_pkg::PMC_OFF: begin
               s_nxt.pwr = pmc_pkg::PMC_POR;
               s_nxt.tmr = 16'h0000;
            end
            pmc_pkg::PMC_POR: begin
               s_nxt.tmr = s_r.tmr + 16'h0001;
               if (s_r.tmr == 16'(pmc_pkg::POR_CYC - 1)) begin
                  s_nxt.pwr = pmc_pkg::PMC_START;
                  s_nxt.tmr = 16'h0000;
               end
            end
            pmc_pkg::PMC_START: begin
               s_nxt.tmr = s_r.tmr + 16'h0001;
               if (s_r.tmr == 16'(pmc_pkg::STARTUP_CYC - 1)) begin
                  s_nxt.pwr = pmc_pkg::PMC_FULL;
               end
            end
            pmc_pkg::PMC_FULL: begin
               if (s_r.cmd_reg[pmc_pkg::B_STANDBY]) begin
                  s_nxt.pwr = pmc_pkg::PMC_STBY;
               end
            end
            pmc_pkg::PMC_STBY: begin
               // Wake on cleared bit, wake byte or wake-up counter
               if (!s_r.cmd_reg[pmc_pkg::B_STANDBY] || wk || wuc_exp) begin
                  s_nxt.pwr = pmc_pkg::PMC_START;
                  s_nxt.tmr = 16'h0000;
                  s_nxt.cmd_reg[pmc_pkg::B_STANDBY] = 1'b0;
                  if (wuc_exp && s_r.wtc[pmc_pkg::B_AUTO_WAKE]) begin
                     s_nxt.cst = pmc_pkg::PMC_CDET;
                  end
               end
            end
            default: s_nxt.pwr = pmc_pkg::PMC_OFF;
         endcase
      end
      // Register access; registers kept across standby
      if (link.wr && ready) begin
         unique case (link.addr)
            pmc_pkg::A_CMD: begin
               s_nxt.cmd_reg = link.wdata;
               s_nxt.cmd = link.wdata[4:0];
               s_nxt.cst = pmc_pkg::PMC_CWAIT;
               s_nxt.txp = 2'b00;
            end
            pmc_pkg::A_CTRL: s_nxt.ctrl = link.wdata;
            pmc_pkg::A_FIFO: s_nxt.flen = (s_r.flen == 4'hF) ? s_r.flen : s_r.flen + 4'h1;
            pmc_pkg::A_IRQ: s_nxt.irq = s_r.irq & ~link.wdata;
            pmc_pkg::A_WUC: s_nxt.wuc_reload = link.wdata;
            pmc_pkg::A_WTC: begin
               s_nxt.wtc = link.wdata;
               s_nxt.wstart = link.wdata[pmc_pkg::B_TIMER_RUN];
            end
            pmc_pkg::A_QMIN: s_nxt.qmin = link.wdata;
            pmc_pkg::A_QMAX: s_nxt.qmax = link.wdata;
            pmc_pkg::A_IMIN: s_nxt.imin = link.wdata;
            pmc_pkg::A_IMAX: s_nxt.imax = link.wdata;
            default: ;
         endcase
      end else if (link.wr && s_r.pwr == pmc_pkg::PMC_STBY && link.addr == pmc_pkg::A_CMD) begin
         s_nxt.cmd_reg[pmc_pkg::B_STANDBY] = link.wdata[pmc_pkg::B_STANDBY];
      end
      // Reads answer only when ready
      if (link.rd && ready) begin
         s_nxt.rvalid = 1'b1;
         unique case (link.addr)
            pmc_pkg::A_CMD: s_nxt.rdata = s_r.cmd_reg;
            pmc_pkg::A_CTRL: s_nxt.rdata = s_r.ctrl;
            pmc_pkg::A_FLEN: s_nxt.rdata = {4'h0, s_r.flen};
            pmc_pkg::A_IRQ: s_nxt.rdata = s_r.irq;
            pmc_pkg::A_WUC: s_nxt.rdata = s_r.wuc_reload;
            pmc_pkg::A_WTC: s_nxt.rdata = s_r.wtc;
            pmc_pkg::A_QMIN: s_nxt.rdata = s_r.qmin;
            pmc_pkg::A_QMAX: s_nxt.rdata = s_r.qmax;
            pmc_pkg::A_IMIN: s_nxt.rdata = s_r.imin;
            pmc_pkg::A_IMAX: s_nxt.rdata = s_r.imax;
            pmc_pkg::A_IRES: s_nxt.rdata = s_r.ires;
            pmc_pkg::A_QRES: s_nxt.rdata = s_r.qres;
            default: s_nxt.rdata = s_r.trim_res;
         endcase
      end
      // Command state machine; FIFO never cleared on start
      if (ready) begin
         unique case (s_r.cst)
            pmc_pkg::PMC_CIDLE: ;
            pmc_pkg::PMC_CWAIT: begin
               if (s_r.cmd == pmc_pkg::C_IDLE) begin
                  s_nxt.cst = pmc_pkg::PMC_CIDLE;
                  s_nxt.irq[pmc_pkg::B_IDLE_IRQ] = 1'b1;
               end else if (s_r.cmd == pmc_pkg::C_DETECT) begin
                  s_nxt.cst = pmc_pkg::PMC_CDET;
               end else if (s_r.flen >= pmc_pkg::pmc_args(s_r.cmd)) begin
                  s_nxt.flen = s_r.flen - pmc_pkg::pmc_args(s_r.cmd);
                  s_nxt.cst = pmc_pkg::PMC_CRUN;
               end
            end
            pmc_pkg::PMC_CRUN: begin
               // Framed transmit: start, data, end, done
               if (s_r.cmd == pmc_pkg::C_TRANSMIT) begin
                  unique case (s_r.txp)
                     2'b00: s_nxt.txp = frame_cfg_i[0] ? 2'b01 : 2'b10;
                     2'b01: s_nxt.txp = 2'b10;
                     2'b10: begin
                        if (s_r.flen != 4'h0) begin
                           s_nxt.flen = s_r.flen - 4'h1;
                        end else begin
                           s_nxt.txp = frame_cfg_i[1] ? 2'b11 : 2'b00;
                           s_nxt.cst = frame_cfg_i[1] ? pmc_pkg::PMC_CRUN : pmc_pkg::PMC_CIDLE;
                        end
                     end
                     default: begin
                        s_nxt.txp = 2'b00;
                        s_nxt.cst = pmc_pkg::PMC_CIDLE;
                     end
                  endcase
               end else begin
                  s_nxt.cst = pmc_pkg::PMC_CIDLE;
                  s_nxt.irq[pmc_pkg::B_IDLE_IRQ] = 1'b1;
               end
            end
            pmc_pkg::PMC_CDET: begin
               // Detection phase: sample and compare
               s_nxt.ires = i_sample_i;
               s_nxt.qres = q_sample_i;
               hit = (i_sample_i < s_r.imin) || (i_sample_i > s_r.imax)
                  || (q_sample_i < s_r.qmin) || (q_sample_i > s_r.qmax);
               s_nxt.cst = pmc_pkg::PMC_CIDLE;
               if (hit) begin
                  s_nxt.irq[pmc_pkg::B_CD_IRQ] = 1'b1;
                  s_nxt.wstop = 1'b1;
               end else if (s_r.wtc[pmc_pkg::B_AUTO_WAKE] && wuc_run) begin
                  s_nxt.cmd_reg[pmc_pkg::B_STANDBY] = 1'b1;
               end // Otherwise stay awake
            end
            default: s_nxt.cst = pmc_pkg::PMC_CIDLE;
         endcase
      end
      // Oscillator trim: crystal cycles per oscillator period
      s_nxt.trim_div = (s_r.trim_div == 16'(pmc_pkg::LPO_DIV * 2 - 1)) ? 16'h0000
         : s_r.trim_div + 16'h0001;
      s_nxt.trim_cnt = s_r.trim_cnt + 8'h01;
      if (s_r.trim_div == 16'h0000) begin
         s_nxt.trim_res = s_r.trim_cnt;
         s_nxt.trim_cnt = 8'h01; // Capture cycle opens the new period
      end
      // Outputs: released in power-down, pins kept driven in standby
      s_nxt.oe = (s_nxt.pwr != pmc_pkg::PMC_OFF);
      // Modem and full-mode flag drop in standby
      s_nxt.full = (s_nxt.pwr == pmc_pkg::PMC_FULL);
      s_nxt.tx = s_nxt.full && !s_nxt.ctrl[pmc_pkg::B_MODEM];
      s_nxt.rx = s_nxt.full && !s_nxt.ctrl[pmc_pkg::B_MODEM];
      s_nxt.stby = (s_nxt.pwr == pmc_pkg::PMC_STBY);
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign link.rdata = s_r.rdata;
   assign link.rvalid = s_r.rvalid;
   assign full_mode_o = s_r.full;
   assign standby_o = s_r.stby;
   assign tx_on_o = s_r.tx;
   assign rx_on_o = s_r.rx;
   assign pins_oe_o = s_r.oe;
   assign tx_phase_o = s_r.txp;
   assign active_cmd_o = s_r.cmd;
   assign trim_count_o = s_r.trim_res;
endmodule : pmc_device

// ==== src/pmc_host.sv ====
// Host end: register port to link, power-down pulse and wake byte
`timescale 1ns/1ps
module pmc_host (
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   pmc_link_if.host link,
   input wire logic [6:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic reset_req_i,
   input wire logic wake_req_i,
   output logic [7:0] rdata_o,
   output logic rvalid_o,
   output logic busy_o
);
   typedef struct packed {
      logic pd;
      logic [15:0] cnt;
      logic wr, rd, wake;
      logic [6:0] addr;
      logic [7:0] wdata, rdata;
      logic rvalid;
   } pmc_host_t;
   pmc_host_t s_r, s_nxt;

   // Forward strobes; hold power-down for reset
   always_comb begin
      s_nxt = s_r;
      s_nxt.wr = wr_i;
      s_nxt.rd = rd_i;
      s_nxt.addr = addr_i;
      s_nxt.wdata = wdata_i;
      s_nxt.wake = wake_req_i;
      s_nxt.rvalid = link.rvalid;
      s_nxt.rdata = link.rdata;
      if (reset_req_i && !s_r.pd) begin
         s_nxt.pd = 1'b1;
         s_nxt.cnt = 16'h0000;
      end else if (s_r.pd) begin
         s_nxt.cnt = s_r.cnt + 16'h0001;
         if (s_r.cnt == 16'(pmc_pkg::PDN_HOLD_CYC - 1)) begin
            s_nxt.pd = 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign link.power_down_pin = s_r.pd;
   assign link.wr = s_r.wr;
   assign link.rd = s_r.rd;
   assign link.uart_wake = s_r.wake;
   assign link.addr = s_r.addr;
   assign link.wdata = s_r.wdata;
   assign rdata_o = s_r.rdata;
   assign rvalid_o = s_r.rvalid;
   assign busy_o = s_r.pd;
endmodule : pmc_host

// ==== verif/pmc_properties.sv ====
// Checker: timing relations on the link and the device's power outputs
`timescale 1ns/1ps
module pmc_properties (
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   input wire logic power_down_pin,
   input wire logic wr,
   input wire logic rd,
   input wire logic [6:0] addr,
   input wire logic [7:0] wdata,
   input wire logic rvalid,
   input wire logic full_mode_o,
   input wire logic standby_o,
   input wire logic tx_on_o,
   input wire logic rx_on_o,
   input wire logic pins_oe_o,
   input wire logic [1:0] tx_phase_o,
   input wire logic [4:0] active_cmd_o
);
   logic [11:0] pdn_cnt_r;
   // Cycles the power-down pin has stayed high
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i || !power_down_pin)
         pdn_cnt_r <= 12'h000;
      else
         pdn_cnt_r <= pdn_cnt_r + 12'h001;
   end
   localparam int START_LIMIT = pmc_pkg::POR_CYC + pmc_pkg::STARTUP_CYC + 16;
   logic [11:0] start_cnt_r;
   // Cycles spent starting up: not full, not in standby, pin low
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i || power_down_pin || full_mode_o || standby_o)
         start_cnt_r <= 12'h000;
      else
         start_cnt_r <= start_cnt_r + 12'h001;
   end
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rstn_i);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   property p_pdn_off;
      power_down_pin && pdn_cnt_r >= 12'h003 |-> !pins_oe_o && !full_mode_o;
   endproperty
   a_pdn_off: assert property (p_pdn_off) else $error("outputs live in power-down");
   property p_pdn_hold;
      $fell(power_down_pin) |-> pdn_cnt_r >= pmc_pkg::PDN_HOLD_CYC;
   endproperty
   a_pdn_hold: assert property (p_pdn_hold) else $error("power-down pulse too short");
   property p_rd_answer;
      rvalid |-> $past(rd);
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("answer without read");
   property p_refuse;
      rd && !full_mode_o |=> !rvalid;
   endproperty
   a_refuse: assert property (p_refuse) else $error("read answered before ready");
   property p_por_seq;
      $fell(power_down_pin) |-> !full_mode_o [*8];
   endproperty
   a_por_seq: assert property (p_por_seq) else $error("start-up after power-down wrong");
   property p_stby_exit;
      $fell(standby_o) && !power_down_pin |-> !full_mode_o [*8];
   endproperty
   a_stby_exit: assert property (p_stby_exit) else $error("start-up after standby wrong");
   property p_start_bound;
      start_cnt_r < START_LIMIT;
   endproperty
   a_start_bound: assert property (p_start_bound) else $error("start-up did not finish");
   property p_stby_quiet;
      standby_o && $past(standby_o) |-> !tx_on_o && !rx_on_o && !full_mode_o;
   endproperty
   a_stby_quiet: assert property (p_stby_quiet) else $error("modem active in standby");
   property p_stby_hold;
      standby_o && $past(standby_o) |-> pins_oe_o && $stable(tx_phase_o);
   endproperty
   a_stby_hold: assert property (p_stby_hold) else $error("outputs moved in standby");
   property p_idle;
      wr && addr == pmc_pkg::A_CMD && wdata == 8'h00 && full_mode_o
         |=> active_cmd_o == pmc_pkg::C_IDLE;
   endproperty
   a_idle: assert property (p_idle) else $error("idle code did not cancel");
   // Main scenarios reached
   c_read: cover property (rvalid);
   c_stby: cover property ($fell(standby_o));
   c_tx_end: cover property (tx_phase_o == 2'h3);
endmodule : pmc_properties

// ==== verif/power_mode_and_command_control_tb.sv ====
// Testbench: host and device ends joined over the link
`timescale 1ns/1ps
module power_mode_and_command_control_tb;
   logic sys_clk_i, rstn_i, wr_i, rd_i, reset_req_i, wake_req_i, ok;
   logic rvalid_o, busy_o, full_mode_o, standby_o, tx_on_o, rx_on_o, pins_oe_o;
   logic [6:0] addr_i;
   logic [6:0] la [4];
   logic [7:0] wdata_i, i_sample_i, q_sample_i, frame_cfg_i, rdata_o, trim_count_o, d;
   logic [7:0] lim [4];
   logic [1:0] tx_phase_o;
   logic [4:0] active_cmd_o;
   logic [1:0] ph [$];
   int failures, n_checks, cyc, seed, t, k;
   pmc_link_if pmc_link_if_inst ();
   pmc_host pmc_host_inst (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .link(pmc_link_if_inst),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .reset_req_i(reset_req_i),
      .wake_req_i(wake_req_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .busy_o(busy_o));
   pmc_device pmc_device_inst (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .link(pmc_link_if_inst),
      .i_sample_i(i_sample_i), .q_sample_i(q_sample_i), .frame_cfg_i(frame_cfg_i),
      .full_mode_o(full_mode_o), .standby_o(standby_o), .tx_on_o(tx_on_o), .rx_on_o(rx_on_o),
      .pins_oe_o(pins_oe_o), .tx_phase_o(tx_phase_o), .active_cmd_o(active_cmd_o),
      .trim_count_o(trim_count_o));
   pmc_properties pmc_properties_inst (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
      .power_down_pin(pmc_link_if_inst.power_down_pin), .wr(pmc_link_if_inst.wr),
      .rd(pmc_link_if_inst.rd), .addr(pmc_link_if_inst.addr), .wdata(pmc_link_if_inst.wdata),
      .rvalid(pmc_link_if_inst.rvalid), .full_mode_o(full_mode_o), .standby_o(standby_o),
      .tx_on_o(tx_on_o), .rx_on_o(rx_on_o), .pins_oe_o(pins_oe_o), .tx_phase_o(tx_phase_o),
      .active_cmd_o(active_cmd_o));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask : chk
   task automatic give_verdict;
      if (failures == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : give_verdict
   task automatic wr(input logic [6:0] a, input logic [7:0] v);
      @(posedge sys_clk_i);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge sys_clk_i);
      wr_i <= 1'b0;
   endtask : wr
   task automatic rd(input logic [6:0] a, output logic [7:0] v, output logic got);
      @(posedge sys_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge sys_clk_i);
      rd_i <= 1'b0;
      got = 1'b0;
      v = 8'h00;
      for (int i = 0; i < 6 && !got; i++) begin
         @(posedge sys_clk_i);
         if (rvalid_o === 1'b1) begin
            got = 1'b1;
            v = rdata_o;
         end
      end
   endtask : rd
   task automatic wait_full(output int n);
      n = 0;
      while (full_mode_o !== 1'b1 && n < 4000) begin
         @(posedge sys_clk_i);
         n++;
      end
      chk(full_mode_o, 1'b1);
   endtask : wait_full
   // Clock and hang limit
   initial begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end
   always @(posedge sys_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         failures++;
         give_verdict();
      end
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      seed = 44;
      cyc = 0;
      failures = 0;
      n_checks = 0;
      {rstn_i, wr_i, rd_i, reset_req_i, wake_req_i} = 5'h00;
      addr_i = 7'h00;
      wdata_i = 8'h00;
      i_sample_i = 8'h00;
      q_sample_i = 8'h00;
      frame_cfg_i = 8'h03;
      la = '{pmc_pkg::A_QMIN, pmc_pkg::A_QMAX, pmc_pkg::A_IMIN, pmc_pkg::A_IMAX};
      repeat (4) @(posedge sys_clk_i);
      rstn_i <= 1'b1;
      wait_full(t);
      chk(t >= pmc_pkg::STARTUP_CYC, 1);
      rd(7'h7F, d, ok);
      chk(ok, 1'b1);
      // Detection limits, then random samples against them
      for (k = 0; k < 4; k++) begin
         lim[k] = 8'($random(seed)) & 8'h3F;
         lim[k] = lim[k] + ((k % 2) ? 8'hB0 : 8'h10);
         wr(la[k], lim[k]);
      end
      for (k = 0; k < 6; k++) begin
         i_sample_i <= (k == 0) ? lim[2] : 8'($random(seed));
         q_sample_i <= (k == 0) ? lim[1] : 8'($random(seed));
         wr(pmc_pkg::A_IRQ, 8'h03);
         wr(pmc_pkg::A_CMD, {3'h0, pmc_pkg::C_DETECT});
         repeat (4) @(posedge sys_clk_i);
         rd(pmc_pkg::A_IRQ, d, ok);
         chk(d[0], i_sample_i < lim[2] || i_sample_i > lim[3] ||
            q_sample_i < lim[0] || q_sample_i > lim[1]);
         rd(pmc_pkg::A_IRES, d, ok);
         chk(d, i_sample_i);
         chk(standby_o, 1'b0);
      end
      wr(pmc_pkg::A_CTRL, 8'h40);
      repeat (3) @(posedge sys_clk_i);
      chk({tx_on_o, rx_on_o}, 2'b00);
      wr(pmc_pkg::A_CTRL, 8'h00);
      // Short argument list, cancel, then framed transmit
      for (k = 0; k < 3; k++)
         wr(pmc_pkg::A_FIFO, 8'($random(seed)));
      wr(pmc_pkg::A_CMD, {3'h0, pmc_pkg::C_LOADKEY});
      repeat (20) @(posedge sys_clk_i);
      chk(active_cmd_o, pmc_pkg::C_LOADKEY);
      rd(pmc_pkg::A_IRQ, d, ok);
      chk(d[1], 1'b0);
      wr(pmc_pkg::A_CMD, 8'h00);
      repeat (3) @(posedge sys_clk_i);
      chk(active_cmd_o, pmc_pkg::C_IDLE);
      rd(pmc_pkg::A_FLEN, d, ok);
      chk(d, 8'h03);
      wr(pmc_pkg::A_FIFO, 8'h5A);
      wr(pmc_pkg::A_CMD, {3'h0, pmc_pkg::C_TRANSMIT});
      for (t = 0; t < 300; t++) begin
         @(posedge sys_clk_i);
         if (tx_phase_o !== 2'h0 && (ph.size() == 0 || ph[$] !== tx_phase_o))
            ph.push_back(tx_phase_o);
      end
      chk(ph.size(), 3);
      for (k = 0; k < 3; k++)
         chk(ph[k], k + 1);
      // Standby by bit, leave by bit, then by wake byte
      wr(pmc_pkg::A_CMD, 8'h80);
      repeat (3) @(posedge sys_clk_i);
      chk({standby_o, full_mode_o}, 2'b10);
      rd(pmc_pkg::A_QMIN, d, ok);
      chk(ok, 1'b0);
      wr(pmc_pkg::A_CMD, 8'h00);
      wait_full(t);
      chk(t >= pmc_pkg::STARTUP_CYC - 2, 1);
      rd(pmc_pkg::A_QMIN, d, ok);
      chk(d, lim[0]);
      wr(pmc_pkg::A_CMD, 8'h80);
      repeat (3) @(posedge sys_clk_i);
      wake_req_i <= 1'b1;
      ok = 1'b0;
      for (k = 0; k < 400 && !ok; k++)
         rd(pmc_pkg::A_CMD, d, ok);
      chk(ok, 1'b1);
      chk(d, 8'h00);
      wake_req_i <= 1'b0;
      // Hard power-down pulse and restart
      reset_req_i <= 1'b1;
      @(posedge sys_clk_i);
      reset_req_i <= 1'b0;
      t = 0;
      for (k = 0; k < 1200 && !(t > 0 && pmc_link_if_inst.power_down_pin !== 1'b1); k++) begin
         @(posedge sys_clk_i);
         if (pmc_link_if_inst.power_down_pin === 1'b1)
            t++;
         if (k == 500)
            chk({pins_oe_o, busy_o}, 2'b01);
      end
      chk(t, pmc_pkg::PDN_HOLD_CYC);
      wait_full(t);
      chk(t >= pmc_pkg::STARTUP_CYC, 1);
      // Periodic detection by wake-up timer: empty field, then a card
      i_sample_i <= lim[2];
      q_sample_i <= lim[0];
      wr(pmc_pkg::A_IRQ, 8'h03);
      wr(pmc_pkg::A_WUC, 8'h00);
      wr(pmc_pkg::A_WTC, 8'h07);
      wr(pmc_pkg::A_CMD, 8'h80);
      repeat (4) @(posedge sys_clk_i);
      chk(standby_o, 1'b1);
      for (k = 0; k < 8000 && standby_o === 1'b1; k++)
         @(posedge sys_clk_i);
      chk(standby_o, 1'b0);
      for (k = 0; k < 2000 && standby_o !== 1'b1; k++)
         @(posedge sys_clk_i);
      chk(standby_o, 1'b1);
      q_sample_i <= 8'hFF;
      for (k = 0; k < 8000 && standby_o === 1'b1; k++)
         @(posedge sys_clk_i);
      wait_full(t);
      repeat (4) @(posedge sys_clk_i);
      chk(standby_o, 1'b0);
      rd(pmc_pkg::A_IRQ, d, ok);
      chk(d[0], 1'b1);
      rd(pmc_pkg::A_QRES, d, ok);
      chk(d, 8'hFF);
      chk(trim_count_o, 8'((pmc_pkg::CLK_MHZ * 1000) / pmc_pkg::LPO_KHZ));
      give_verdict();
   end
endmodule : power_mode_and_command_control_tb
